// ==== logic/pidt_core.sv ====
`timescale 1ns/1ps
// Contract
// - start-up message vector sets fetch address
// - spurious bit 8 enables controller; error entry
// - extended mode returns 32-bit identifier equal leaf
// - legacy mode returns 8-bit identifier
// - power-up identifier reported in bits 31:24
// - leaf fourth result holds unique 32-bit identifier
// - identifier has at most four fields
// - fields align to hierarchy bit boundaries
// - server layout: bits 2:1 package number
// - server layout: bits 4:3 cluster number
// - server layout: bit 0 thread, zero without threads
// - oldest layout: bits 1:0 processor, 3:2 cluster
// - enable bit zero after reset
module pidt_core
	import pidt_pkg::*;
#(
	parameter pidt_layout_t LAYOUT     = PIDT_LAYOUT_SERVER,
	parameter logic         HAS_THREADS = 1'b1
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// strap pins giving the position in the system
	input  wire logic [1:0]  strap_cluster,
	input  wire logic [1:0]  strap_package,
	input  wire logic [1:0]  strap_core,
	input  wire logic        strap_thread,
	// start-up and restart messages from the interrupt fabric
	input  wire logic        startup_ipi_message,
	input  wire logic [7:0]  startup_vector,
	input  wire logic        restart_interrupt_message,
	// execution control
	input  wire logic        halt_request,
	output logic             fetch_start,
	output logic      [31:0] fetch_address,
	output logic             ctrl_enabled
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [6:0] strap_s1_q, strap_s2_q;
	logic [2:0] msg_s1_q, msg_s2_q, msg_s3_q;
	logic [7:0] vec_s1_q, vec_s2_q;
	logic [1:0] strap_age_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_s1_q   <= '0;
			strap_s2_q   <= '0;
			msg_s1_q     <= '0;
			msg_s2_q     <= '0;
			msg_s3_q     <= '0;
			vec_s1_q     <= '0;
			vec_s2_q     <= '0;
			strap_age_q  <= '0;
		end else begin
			strap_s1_q   <= {strap_cluster, strap_package, strap_core,
				strap_thread};
			strap_s2_q   <= strap_s1_q;
			msg_s1_q     <= {startup_ipi_message,
				restart_interrupt_message, halt_request};
			msg_s2_q     <= msg_s1_q;
			msg_s3_q     <= msg_s2_q;
			vec_s1_q     <= startup_vector;
			vec_s2_q     <= vec_s1_q;
			// saturate so the capture point is seen exactly once
			if (strap_age_q != PIDT_STRAP_DONE)
				strap_age_q <= strap_age_q + PIDT_STRAP_STEP;
		end
	end

	logic start_evt, restart_evt, halt_evt;
	assign start_evt   = msg_s2_q[2] & ~msg_s3_q[2];
	assign restart_evt = msg_s2_q[1] & ~msg_s3_q[1];
	assign halt_evt    = msg_s2_q[0] & ~msg_s3_q[0];

	// ----------------------------------------------------------------
	// power-up identifier composition
	// ----------------------------------------------------------------
	pidt_topo_t topo;
	logic [31:0] power_id;

	always_comb begin
		topo = pidt_topo_t'(strap_s2_q);
		if (!HAS_THREADS)
			topo.thread = 1'b0;
		power_id = '0;
		unique case (LAYOUT)
		PIDT_LAYOUT_OLDEST: begin
			power_id[1:0] = topo.package_no;
			power_id[3:2] = topo.cluster;
		end
		PIDT_LAYOUT_SERVER: begin
			power_id[0]   = topo.thread;
			power_id[2:1] = topo.package_no;
			power_id[4:3] = topo.cluster;
		end
		default: begin
			// thread, core, package, cluster on aligned boundaries
			power_id[0]   = topo.thread;
			power_id[2:1] = topo.core;
			power_id[4:3] = topo.package_no;
			power_id[6:5] = topo.cluster;
		end
		endcase
	end

	// ----------------------------------------------------------------
	// state update
	// ----------------------------------------------------------------
	pidt_regs_t r_q, r_d;
	logic        acc, wr, rd;
	logic [31:0] rdv;
	logic        hit;

	assign acc = psel & penable;
	assign wr  = acc & pwrite;
	assign rd  = acc & ~pwrite;

	always_comb begin
		r_d         = r_q;
		r_d.fetch_go = 1'b0;
		// capture initial identifier once both sync stages hold straps
		if (strap_age_q == PIDT_STRAP_CAPTURE) begin
			r_d.init_id = power_id;
			r_d.cur_id  = power_id;
		end
		// read mux: pure function of state, no side effects
		hit = 1'b1;
		rdv = '0;
		unique case (paddr & PIDT_OFF_MASK)
		PIDT_OFF_LOCAL_ID:
			rdv = {r_q.cur_id[7:0], 24'h000000};
		PIDT_OFF_SPURIOUS:   rdv = r_q.spurious;
		PIDT_OFF_ERROR_LVT:  rdv = r_q.error_lvt;
		PIDT_OFF_EXT_ID:
			rdv = r_q.ext_mode ? r_q.cur_id : 32'h0;
		PIDT_OFF_INIT_ID:
			rdv = {r_q.init_id[7:0], 24'h000000};
		PIDT_OFF_LEAF_B_EDX: rdv = r_q.cur_id;
		PIDT_OFF_MODE:       rdv = {31'h0, r_q.ext_mode};
		PIDT_OFF_START_VEC:  rdv = {24'h000000, r_q.start_vec};
		PIDT_OFF_STATUS:     rdv = {30'h0, r_q.st};
		PIDT_OFF_TOPO:       rdv = {25'h0, strap_s2_q};
		default:             hit = 1'b0;
		endcase
		r_d.pready  = 1'b0;
		r_d.pslverr = 1'b0;
		if (psel && !penable) begin
			r_d.pready  = 1'b1;
			r_d.pslverr = ~hit;
			r_d.prdata  = pwrite ? 32'h0 : rdv;
		end
		if (wr && r_q.pready) begin
			unique case (paddr & PIDT_OFF_MASK)
			PIDT_OFF_LOCAL_ID:
				// only the current id moves; initial stays put
				if (!r_q.ext_mode)
					r_d.cur_id = {24'h0,
						pwdata[PIDT_LEGACY_ID_LSB +: 8]};
			PIDT_OFF_SPURIOUS:  r_d.spurious  = pwdata;
			PIDT_OFF_ERROR_LVT: r_d.error_lvt = pwdata;
			PIDT_OFF_MODE:      r_d.ext_mode  = pwdata[0];
			default: ;
			endcase
		end
		unique case (r_q.st)
		PIDT_ST_WAIT_START:
			if (start_evt) begin
				r_d.start_vec = vec_s2_q & PIDT_VEC_MASK;
				r_d.fetch_go  = 1'b1;
				r_d.st        = PIDT_ST_RUN;
			end
		PIDT_ST_RUN:
			if (halt_evt)
				r_d.st = PIDT_ST_HALTED;
		PIDT_ST_HALTED: ;
		default: r_d.st = PIDT_ST_WAIT_START;
		endcase
		if (restart_evt)
			r_d.st = PIDT_ST_WAIT_START;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_q           <= '0;
			r_q.spurious  <= PIDT_SPURIOUS_RST;
			r_q.error_lvt <= PIDT_ERROR_LVT_RST;
			r_q.st        <= PIDT_ST_WAIT_START;
		end else begin
			r_q <= r_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign prdata        = r_q.prdata;
	assign pready        = r_q.pready;
	assign pslverr       = r_q.pslverr;
	assign fetch_start   = r_q.fetch_go;
	assign fetch_address = {12'h000, r_q.start_vec, PIDT_PAGE_ZERO};
	assign ctrl_enabled  = r_q.spurious[PIDT_ENABLE_BIT];

endmodule // pidt_core

// ==== logic/pidt_pkg.sv ====
package pidt_pkg;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] PIDT_OFF_LOCAL_ID    = 12'h020;
	localparam logic [11:0] PIDT_OFF_SPURIOUS    = 12'h0f0;
	localparam logic [11:0] PIDT_OFF_ERROR_LVT   = 12'h370;
	localparam logic [11:0] PIDT_OFF_EXT_ID      = 12'h800;
	localparam logic [11:0] PIDT_OFF_INIT_ID     = 12'h804;
	localparam logic [11:0] PIDT_OFF_LEAF_B_EDX  = 12'h808;
	localparam logic [11:0] PIDT_OFF_MODE        = 12'h80c;
	localparam logic [11:0] PIDT_OFF_START_VEC   = 12'h810;
	localparam logic [11:0] PIDT_OFF_STATUS      = 12'h814;
	localparam logic [11:0] PIDT_OFF_TOPO        = 12'h818;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int          PIDT_ENABLE_BIT      = 8;
	localparam int          PIDT_LEGACY_ID_LSB   = 24;
	localparam int          PIDT_INITID_LSB      = 24;
	localparam logic [31:0] PIDT_SPURIOUS_RST    = 32'h0000_00ff;
	localparam logic [31:0] PIDT_ERROR_LVT_RST   = 32'h0001_0000;
	localparam logic [7:0]  PIDT_VEC_MASK        = 8'hff;
	localparam logic [11:0] PIDT_PAGE_ZERO       = 12'h000;
	localparam logic [11:0] PIDT_OFF_MASK        = 12'hfff;
	// strap settling: capture once the second stage holds the pins
	localparam logic [1:0]  PIDT_STRAP_CAPTURE   = 2'h2;
	localparam logic [1:0]  PIDT_STRAP_DONE      = 2'h3;
	localparam logic [1:0]  PIDT_STRAP_STEP      = 2'h1;

	// ----------------------------------------------------------------
	// identifier layout variants
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PIDT_LAYOUT_OLDEST = 2'h0,
		PIDT_LAYOUT_SERVER = 2'h1,
		PIDT_LAYOUT_WIDE   = 2'h2
	} pidt_layout_t;

	typedef enum logic [1:0] {
		PIDT_ST_WAIT_START = 2'b00,
		PIDT_ST_RUN        = 2'b01,
		PIDT_ST_HALTED     = 2'b11
	} pidt_state_t;

	typedef struct packed {
		logic [31:0] cur_id;
		logic [31:0] init_id;
		logic [31:0] spurious;
		logic [31:0] error_lvt;
		logic        ext_mode;
		logic [7:0]  start_vec;
		logic        fetch_go;
		pidt_state_t st;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} pidt_regs_t;

	typedef struct packed {
		logic [1:0] cluster;
		logic [1:0] package_no;
		logic [1:0] core;
		logic       thread;
	} pidt_topo_t;

endpackage

// ==== verification/pidt_core_properties.sv ====
`timescale 1ns/1ps
module pidt_core_chk
	import pidt_pkg::*;
(
	// clock, reset and apb
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// execution control
	input wire logic [7:0]  startup_vector,
	input wire logic        fetch_start,
	input wire logic [31:0] fetch_address,
	input wire logic        ctrl_enabled
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_wr_svr;
		psel && penable && pready && pwrite && paddr == PIDT_OFF_SPURIOUS;
	endsequence
	property p_ready_after_setup;
		s_setup |=> pready;
	endproperty
	property p_ready_one;
		pready |=> !pready;
	endproperty
	property p_idle_no_ready;
		!psel |=> !pready;
	endproperty
	property p_err_with_ready;
		pslverr |-> pready;
	endproperty
	property p_err_zero_data;
		pready && pslverr |-> prdata == 32'h0;
	endproperty
	property p_enable;
		s_wr_svr |=> ##1 ctrl_enabled == $past(pwdata[PIDT_ENABLE_BIT], 2);
	endproperty
	property p_fetch_pulse;
		fetch_start |=> !fetch_start;
	endproperty
	property p_fetch_addr;
		fetch_start |-> fetch_address == {12'h0, $past(startup_vector, 3), 12'h0};
	endproperty
	a_ready_after_setup: assert property (p_ready_after_setup)
		else $error("no ready after setup");
	a_ready_one: assert property (p_ready_one)
		else $error("ready longer than one cycle");
	a_idle_no_ready: assert property (p_idle_no_ready)
		else $error("ready without request");
	a_err_with_ready: assert property (p_err_with_ready)
		else $error("error without ready");
	a_err_zero_data: assert property (p_err_zero_data)
		else $error("data on error");
	a_enable: assert property (p_enable)
		else $error("enable does not follow bit 8");
	a_fetch_pulse: assert property (p_fetch_pulse)
		else $error("fetch start too long");
	a_fetch_addr: assert property (p_fetch_addr)
		else $error("fetch address wrong");
endmodule // pidt_core_chk

// ==== verification/pidt_core_tb_top.sv ====
`timescale 1ns/1ps
module pidt_core_tb_top;
	import pidt_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, err, ipi, rmsg, halt;
	logic        fst, ctrl_en;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, faddr;
	logic        pready, pslverr;
	logic [7:0]  vec;
	logic [6:0]  strap;
	int          n_errors, check_count, i;
	pidt_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.strap_cluster(strap[6:5]), .strap_package(strap[4:3]),
		.strap_core(strap[2:1]), .strap_thread(strap[0]),
		.startup_ipi_message(ipi), .startup_vector(vec),
		.restart_interrupt_message(rmsg), .halt_request(halt),
		.fetch_start(fst), .fetch_address(faddr), .ctrl_enabled(ctrl_en));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	initial begin
		repeat (3000) @(posedge pclk);
		n_errors++;
		close_out;
	end
	initial begin
		{presetn, psel, penable, pwrite, ipi, rmsg, halt} = 7'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		vec = 8'hbd;
		strap = 7'b10_01_00_1;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		// -------------------------------------------------------------
		// reset values, identifiers, mode, enable
		// -------------------------------------------------------------
		chk({31'h0, ctrl_en}, 32'h0);
		rdc(PIDT_OFF_SPURIOUS, 32'h0000_00ff);
		rdc(PIDT_OFF_INIT_ID, 32'h1300_0000);
		rdc(PIDT_OFF_LOCAL_ID, 32'h1300_0000);
		rdc(PIDT_OFF_LEAF_B_EDX, 32'h0000_0013);
		rdc(PIDT_OFF_EXT_ID, 32'h0);
		xfer(1'b1, PIDT_OFF_MODE, 32'h1);
		rdc(PIDT_OFF_EXT_ID, 32'h0000_0013);
		xfer(1'b1, PIDT_OFF_MODE, 32'h0);
		xfer(1'b1, PIDT_OFF_SPURIOUS, 32'h0000_01ff);
		chk({31'h0, ctrl_en}, 32'h1);
		xfer(1'b1, PIDT_OFF_ERROR_LVT, 32'h0001_0033);
		rdc(PIDT_OFF_ERROR_LVT, 32'h0001_0033);
		$display("test ids done");
		xfer(1'b1, PIDT_OFF_LOCAL_ID, 32'h5a00_0000);
		xfer(1'b1, PIDT_OFF_INIT_ID, 32'h0);
		rdc(PIDT_OFF_LOCAL_ID, 32'h5a00_0000);
		rdc(PIDT_OFF_INIT_ID, 32'h1300_0000);
		rdc(PIDT_OFF_INIT_ID, 32'h1300_0000);
		xfer(1'b0, 12'h100, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		$display("test writes done");
		// -------------------------------------------------------------
		// start-up, halt and restart
		// -------------------------------------------------------------
		ipi <= 1'b1;
		i = 0;
		while (fst !== 1'b1 && i < 10) begin
			@(posedge pclk);
			i++;
		end
		chk({31'h0, fst}, 32'h1);
		chk(faddr, 32'h000b_d000);
		rdc(PIDT_OFF_STATUS, 32'h1);
		halt <= 1'b1;
		repeat (5) @(posedge pclk);
		rdc(PIDT_OFF_STATUS, 32'h3);
		rmsg <= 1'b1;
		repeat (5) @(posedge pclk);
		rdc(PIDT_OFF_STATUS, 32'h0);
		$display("test start done");
		close_out;
	end
endmodule // pidt_core_tb_top
bind pidt_core pidt_core_chk u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.startup_vector(startup_vector), .fetch_start(fetch_start),
	.fetch_address(fetch_address), .ctrl_enabled(ctrl_enabled));
